// ==== slsr_pkg.sv ====
// Package for the link sync request input block: constants and carrier types.
// Assumes one 10 MHz reference clock and a synchronous active-high reset.
// Function
// - In 8b/10b with source select clear, the single-ended pin is an active-low link request.
// - In 64b/66b the sync input skips link setup but may still sync oscillators.
// - Selected sync going low in 8b/10b starts code group synchronization.
// - Receiver raises sync after alignment; that rising edge starts the alignment sequence.
// - Source select set takes the request from the differential marker pair.
// - The differential marker pair is read active low, like the single-ended pin.
// - The differential marker input responds only while its receiver enable is one.
package slsr_pkg;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam logic SEL_SINGLE = 1'h0;
    localparam logic SEL_DIFF = 1'h1;
    localparam logic MODE_8B10B = 1'h0;
    localparam logic MODE_64B66B = 1'h1;
    localparam logic RX_ENABLED = 1'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SLSR_IDLE,
        SLSR_CGS,
        SLSR_ILAS,
        SLSR_DATA
    } slsr_state_e;

    typedef struct packed {
        logic link_mode;
        logic sync_select;
        logic marker_receiver_enable;
    } slsr_cfg_s;

    typedef struct packed {
        logic cgs_active;
        logic ilas_start;
        logic ilas_active;
        logic data_active;
        logic nco_sync;
    } slsr_status_s;

endpackage : slsr_pkg

// ==== slsr_sync_input.sv ====
// Link sync request input: source select, resampling and link start sequencing.
// Assumes the pins are asynchronous to i_ref_clk and configuration is quasi-static.
`timescale 1ns/10ps
module slsr_sync_input (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire slsr_pkg::slsr_cfg_s i_cfg,
    input wire logic i_single_ended_sync_request_n,
    input wire logic i_differential_marker_input,
    input wire logic i_ilas_done,
    output slsr_pkg::slsr_status_s o_status,
    output logic o_sync_request
);

    // ------------------------------------------------------------
    // Pin resampling
    // ------------------------------------------------------------
    logic [slsr_pkg::SYNC_STAGES-1:0] se_sync;
    logic [slsr_pkg::SYNC_STAGES-1:0] df_sync;
    logic [slsr_pkg::SYNC_STAGES-1:0] next_se_sync;
    logic [slsr_pkg::SYNC_STAGES-1:0] next_df_sync;

    always_comb begin
        next_se_sync = {se_sync[0], i_single_ended_sync_request_n};
        next_df_sync = {df_sync[0], i_differential_marker_input};
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            se_sync <= '1;
            df_sync <= '1;
        end else begin
            se_sync <= next_se_sync;
            df_sync <= next_df_sync;
        end
    end

    // ------------------------------------------------------------
    // Source select and polarity
    // ------------------------------------------------------------
    logic req_now;
    logic req_prev;
    logic next_req_prev;
    logic diff_req;

    always_comb begin
        // Disabled receiver reads as no request
        diff_req = (i_cfg.marker_receiver_enable == slsr_pkg::RX_ENABLED)
                   && !df_sync[1];
        if (i_cfg.sync_select == slsr_pkg::SEL_DIFF) begin
            req_now = diff_req;
        end else begin
            req_now = !se_sync[1];
        end
        next_req_prev = req_now;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            req_prev <= 1'h0;
        end else begin
            req_prev <= next_req_prev;
        end
    end

    // ------------------------------------------------------------
    // Link start sequencing
    // ------------------------------------------------------------
    slsr_pkg::slsr_state_e state;
    slsr_pkg::slsr_state_e next_state;
    slsr_pkg::slsr_status_s next_status;
    logic is_8b10b;
    logic release_edge;

    always_comb begin
        is_8b10b = (i_cfg.link_mode == slsr_pkg::MODE_8B10B);
        release_edge = req_prev && !req_now;
        next_state = state;
        if (!is_8b10b) begin
            next_state = slsr_pkg::SLSR_IDLE;
        end else if (req_now) begin
            next_state = slsr_pkg::SLSR_CGS;
        end else begin
            case (state)
                slsr_pkg::SLSR_IDLE: next_state = slsr_pkg::SLSR_IDLE;
                slsr_pkg::SLSR_CGS: begin
                    if (release_edge) begin
                        next_state = slsr_pkg::SLSR_ILAS;
                    end
                end
                slsr_pkg::SLSR_ILAS: begin
                    if (i_ilas_done) begin
                        next_state = slsr_pkg::SLSR_DATA;
                    end
                end
                slsr_pkg::SLSR_DATA: next_state = slsr_pkg::SLSR_DATA;
                default: next_state = slsr_pkg::SLSR_IDLE;
            endcase
        end
        next_status.cgs_active = (next_state == slsr_pkg::SLSR_CGS);
        next_status.ilas_start = (state == slsr_pkg::SLSR_CGS)
                                 && (next_state == slsr_pkg::SLSR_ILAS);
        next_status.ilas_active = (next_state == slsr_pkg::SLSR_ILAS);
        next_status.data_active = (next_state == slsr_pkg::SLSR_DATA);
        next_status.nco_sync = !is_8b10b && release_edge;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state <= slsr_pkg::SLSR_IDLE;
            o_status <= '0;
            o_sync_request <= 1'h0;
        end else begin
            state <= next_state;
            o_status <= next_status;
            o_sync_request <= req_now;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_req_to_cgs;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (req_now && is_8b10b) |=> o_status.cgs_active;
    endproperty
    a_req_to_cgs: assert property (p_req_to_cgs) else $error("request did not start cgs");

    property p_release_ilas;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (is_8b10b && state == slsr_pkg::SLSR_CGS && release_edge) |=> o_status.ilas_start;
    endproperty
    a_release_ilas: assert property (p_release_ilas) else $error("release missed ilas");

    property p_ilas_cause;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_status.ilas_start |-> $past(release_edge);
    endproperty
    a_ilas_cause: assert property (p_ilas_cause) else $error("ilas without release");

    property p_no_init_64;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !is_8b10b |=> !o_status.cgs_active && !o_status.ilas_active;
    endproperty
    a_no_init_64: assert property (p_no_init_64) else $error("64b66b used sync for setup");

    property p_single_polarity;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_cfg.sync_select == slsr_pkg::SEL_SINGLE) |-> (req_now == !se_sync[1]);
    endproperty
    a_single_polarity: assert property (p_single_polarity) else $error("se polarity");

    property p_diff_select;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_cfg.sync_select == slsr_pkg::SEL_DIFF && i_cfg.marker_receiver_enable)
        |-> (req_now == !df_sync[1]);
    endproperty
    a_diff_select: assert property (p_diff_select) else $error("diff source wrong");

    property p_rx_disabled;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_cfg.sync_select == slsr_pkg::SEL_DIFF && !i_cfg.marker_receiver_enable) |-> !req_now;
    endproperty
    a_rx_disabled: assert property (p_rx_disabled) else $error("disabled rx responded");

    property p_resample_delay;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $fell(i_single_ended_sync_request_n) ##1 !i_single_ended_sync_request_n
        |=> !se_sync[1];
    endproperty
    a_resample_delay: assert property (p_resample_delay) else $error("resample delay");

    // ------------------------------------------------------------
    // Pin to output checks
    // ------------------------------------------------------------
    property p_se_fall;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ((i_cfg.sync_select == slsr_pkg::SEL_SINGLE) && $fell(i_single_ended_sync_request_n))
        ##1 !i_single_ended_sync_request_n ##1 !i_single_ended_sync_request_n
        |=> o_sync_request && (!is_8b10b || o_status.cgs_active);
    endproperty
    a_se_fall: assert property (p_se_fall) else $error("se fall lost");

    property p_se_rise;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ((i_cfg.sync_select == slsr_pkg::SEL_SINGLE) && $rose(i_single_ended_sync_request_n))
        ##1 i_single_ended_sync_request_n ##1 i_single_ended_sync_request_n
        |=> !o_sync_request;
    endproperty
    a_se_rise: assert property (p_se_rise) else $error("se release lost");

    property p_df_fall;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ((i_cfg.sync_select == slsr_pkg::SEL_DIFF) && i_cfg.marker_receiver_enable
         && $fell(i_differential_marker_input))
        ##1 !i_differential_marker_input ##1 !i_differential_marker_input
        |=> o_sync_request;
    endproperty
    a_df_fall: assert property (p_df_fall) else $error("pair fall lost");

    property p_rx_off_out;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_cfg.sync_select == slsr_pkg::SEL_DIFF && !i_cfg.marker_receiver_enable)
        |=> !o_sync_request;
    endproperty
    a_rx_off_out: assert property (p_rx_off_out) else $error("disabled rx output");

    // ------------------------------------------------------------
    // Sequencing checks
    // ------------------------------------------------------------
    property p_nco_pulse;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!is_8b10b && release_edge) |=> o_status.nco_sync;
    endproperty
    a_nco_pulse: assert property (p_nco_pulse) else $error("nco sync missed");

    property p_nco_only_64;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        is_8b10b |=> !o_status.nco_sync;
    endproperty
    a_nco_only_64: assert property (p_nco_only_64) else $error("nco sync in 8b10b");

    property p_no_data_64;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !is_8b10b |=> !o_status.data_active && !o_status.ilas_start;
    endproperty
    a_no_data_64: assert property (p_no_data_64) else $error("64b66b left idle");

    property p_ilas_pulse;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_status.ilas_start |=> !o_status.ilas_start;
    endproperty
    a_ilas_pulse: assert property (p_ilas_pulse) else $error("ilas start too long");

    property p_ilas_hold;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (is_8b10b && state == slsr_pkg::SLSR_ILAS && !req_now && !i_ilas_done)
        |=> o_status.ilas_active;
    endproperty
    a_ilas_hold: assert property (p_ilas_hold) else $error("ilas dropped early");

    property p_ilas_to_data;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (is_8b10b && state == slsr_pkg::SLSR_ILAS && !req_now && i_ilas_done)
        |=> o_status.data_active;
    endproperty
    a_ilas_to_data: assert property (p_ilas_to_data) else $error("data phase missed");

endmodule : slsr_sync_input

// ==== slsr_link_rx_model.sv ====
// Link receiver model: drives the active-low sync request pins.
// Assumes the bench sets i_request and i_use_diff just after a falling edge.
`timescale 1ns/10ps
module slsr_link_rx_model (
    input wire logic i_ref_clk,
    input wire logic i_request,
    input wire logic i_use_diff,
    output logic o_single_ended_sync_request_n,
    output logic o_differential_marker_input
);
    logic toggle = 1'h0;
    always @(negedge i_ref_clk) begin
        toggle <= ~toggle;
    end
    // Unused pin tied low, unused pair carries a changing pattern
    assign o_single_ended_sync_request_n = i_use_diff ? 1'h0 : ~i_request;
    assign o_differential_marker_input = i_use_diff ? ~i_request : toggle;
endmodule : slsr_link_rx_model

// ==== tb_top.sv ====
// Testbench for the link sync request input block.
// Assumes a 10 MHz clock, inputs driven on the falling edge.
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    slsr_pkg::slsr_cfg_s cfg = '0;
    logic req = 1'h0;
    logic use_diff = 1'h0;
    logic ilas_done = 1'h0;
    logic se_n;
    logic diff;
    slsr_pkg::slsr_status_s st;
    logic sreq;
    int failures = 0;
    int total_checks = 0;
    // ----------------------------------------
    // Instances
    // ----------------------------------------
    slsr_sync_input u_slsr_sync_input (.i_ref_clk(clk), .i_sys_rst(rst), .i_cfg(cfg),
        .i_single_ended_sync_request_n(se_n), .i_differential_marker_input(diff),
        .i_ilas_done(ilas_done), .o_status(st), .o_sync_request(sreq));
    slsr_link_rx_model u_slsr_link_rx_model (.i_ref_clk(clk), .i_request(req),
        .i_use_diff(use_diff), .o_single_ended_sync_request_n(se_n),
        .o_differential_marker_input(diff));
    initial begin
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'h1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic do_reset(input logic mode, input logic sel, input logic en);
        @(negedge clk);
        rst = 1'h1;
        cfg = '{mode, sel, en};
        req = 1'h0;
        use_diff = sel;
        wait_n(2);
        rst = 1'h0;
        wait_n(1);
    endtask : do_reset
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_single;
        do_reset(slsr_pkg::MODE_8B10B, slsr_pkg::SEL_SINGLE, 1'h0);
        req = 1'h1;
        wait_n(2);
        chk(sreq === 1'h0, "request too early");
        wait_n(1);
        chk(sreq === 1'h1 && st.cgs_active === 1'h1, "cgs missing");
        req = 1'h0;
        wait_n(2);
        chk(st.ilas_start === 1'h0 && st.cgs_active === 1'h1, "release too early");
        wait_n(1);
        chk(st.ilas_start & st.ilas_active & ~st.cgs_active & ~sreq, "ilas missing");
        wait_n(1);
        chk(st.ilas_start === 1'h0, "ilas start not a pulse");
        ilas_done = 1'h1;
        wait_n(1);
        ilas_done = 1'h0;
        wait_n(1);
        chk(st.data_active === 1'h1, "data phase missing");
    endtask : t_single
    task automatic t_diff;
        do_reset(slsr_pkg::MODE_8B10B, slsr_pkg::SEL_DIFF, 1'h0);
        req = 1'h1;
        wait_n(6);
        chk(sreq === 1'h0 && st.cgs_active === 1'h0, "disabled pair responded");
        do_reset(slsr_pkg::MODE_8B10B, slsr_pkg::SEL_DIFF, slsr_pkg::RX_ENABLED);
        req = 1'h1;
        wait_n(4);
        chk(sreq === 1'h1 && st.cgs_active === 1'h1, "pair request missed");
        req = 1'h0;
        wait_n(3);
        chk(st.ilas_start === 1'h1, "pair release missed");
    endtask : t_diff
    task automatic t_64b;
        do_reset(slsr_pkg::MODE_64B66B, slsr_pkg::SEL_SINGLE, 1'h0);
        req = 1'h1;
        wait_n(6);
        chk(st.cgs_active === 1'h0, "cgs in 64b/66b");
        req = 1'h0;
        wait_n(3);
        chk(st.nco_sync === 1'h1 && st.ilas_start === 1'h0, "nco sync wrong");
    endtask : t_64b
    initial begin
        #200000;
        failures++;
        final_report();
    end
    initial begin
        t_single();
        t_diff();
        t_64b();
        final_report();
    end
endmodule : tb_top
